//--- src/fcrm_top.v
// Function
// - Control mark set when read meets the opposite kind of data mark.
// - Data field CRC failure sets third status byte bit 5.
// - Sector ID track differing from held track sets wrong cylinder.
// - Mismatching ID track equal to FF sets bad track bit.
// - No data mark of either kind sets missing data mark bit.
// - Unused status bits read fixed: SR2 7,3,2 zero; SR3 7 zero, 5,3 one.
// - Fourth byte mirrors write protect, track zero, head, drive selects.
// - Resets: external control, output register, rate register, power on.
// - Any reset aborts operations and returns to idle.
// - Leaving reset clears registers and configure data, enables polling.
// - Hardware reset spares specify data, sets output register reset.
// - Software resets reset core; rate bit self clears; output bit wins.
// - Bits 3 and 2 of config register select compatibility mode.
// - First mode: DMA enable gates interrupt and DMA, density active high.
// - Second mode: DMA enable ignored, always enabled, density active high.
// - Third mode: DMA enable gates, density select active low.
// - DMA unless specify sets the non-DMA bit; request starts each transfer.
// - Config bit 1 selects burst DMA, else single transfer.
// - After reset enter command phase; host writes opcode then parameters.
// - Request drops per byte, returns per parameter, low after last.
// - Data FIFO kept disabled throughout the command phase.
// - Status bytes delivered through data register in result phase.
`timescale 1ns/1ns
`default_nettype none
`include "fcrm_consts.vh"
module fcrm_top (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Avalon-MM slave
  input  wire [2:0] avs_address,
  input  wire       avs_read,
  input  wire       avs_write,
  input  wire [7:0] avs_writedata,
  output reg  [7:0] avs_readdata,
  output reg        avs_waitrequest,
  // External reset control and pin
  input  wire       external_reset_ctl_bit,
  output reg        external_reset_pin_n,
  // Drive cable
  input  wire       write_protect_n,
  input  wire       track_zero_input_n,
  output reg        head_select_output,
  output reg        drive_select_zero_n,
  output reg        drive_select_one_n,
  output reg        density_select_out,
  input  wire       high_density,
  // Data path events from read logic
  input  wire       sector_done,
  input  wire       read_deleted_cmd,
  input  wire       found_data_mark,
  input  wire       found_deleted_mark,
  input  wire       data_crc_bad,
  input  wire [7:0] id_track,
  input  wire [7:0] held_track,
  input  wire       head_sel,
  input  wire [1:0] drive_sel,
  // DMA and interrupt outputs and inputs
  output reg        dma_request,
  input  wire       dma_ack,
  output reg        dma_burst,
  output reg        irq_out,
  input  wire       irq_event,
  // Core status outputs
  output reg        fifo_enable,
  output reg        polling_enable,
  output reg        core_in_reset
);
  // ==========================================================
  // Pin synchronisers
  wire wp_s;
  wire t0_s;
  wire ext_s;
  fcrm_sync u_sync_wp (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  (~write_protect_n),
    .q_out (wp_s)
  );
  fcrm_sync u_sync_t0 (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  (~track_zero_input_n),
    .q_out (t0_s)
  );
  fcrm_sync u_sync_ext (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  (external_reset_ctl_bit),
    .q_out (ext_s)
  );

  // ==========================================================
  // Registers
  localparam PH_CMD  = 2'b00;
  localparam PH_PROC = 2'b01;
  localparam PH_EXEC = 2'b10;
  localparam PH_RES  = 2'b11;

  reg  [7:0] drvout_reg;
  reg        dsr_rst_reg;
  reg  [7:0] cfg_reg;
  reg  [7:0] spec_reg;
  reg  [7:0] sr2_reg;
  reg  [1:0] phase_reg;
  reg  [3:0] proc_cnt_reg;
  reg  [2:0] byte_cnt_reg;
  reg  [2:0] need_reg;
  reg  [1:0] res_cnt_reg;
  reg        req_reg;
  reg        dir_reg;
  reg        invalid_reg;
  reg  [7:0] st0_reg;
  reg        polling_reg;
  reg        fifo_cfg_reg;
  wire [7:0] pm_rdata;

  wire       soft_rst = ~drvout_reg[`FCRM_DRVOUT_RESET_N] | dsr_rst_reg;
  wire       core_rst = soft_rst | ext_s;
  wire [1:0] mode     = {cfg_reg[`FCRM_CFG_IDENT], cfg_reg[`FCRM_CFG_ENC]};
  wire       is_second = (mode == `FCRM_MODE_SECOND);
  wire       is_third  = (mode == `FCRM_MODE_THIRD);
  wire       gate_en  = is_second | drvout_reg[`FCRM_DRVOUT_DMAEN];
  wire       dma_mode = ~spec_reg[`FCRM_SPEC_NDMA];

  wire       acc      = avs_read | avs_write;
  wire       bus_go   = acc & avs_waitrequest;
  wire       wr_go    = bus_go & avs_write;
  wire       rd_go    = bus_go & avs_read;
  wire       cmd_wr   = wr_go && (avs_address == `FCRM_IDX_DATA) &&
                        (phase_reg == PH_CMD) && req_reg && !dir_reg;
  wire       res_rd   = rd_go && (avs_address == `FCRM_IDX_DATA) &&
                        (phase_reg == PH_RES);

  // Parameter count per opcode
  reg  [2:0] opc_need;
  reg        opc_ok;
  always @* begin
    opc_need = 3'h0;
    opc_ok   = 1'b1;
    case (avs_writedata[4:0])
      `FCRM_OPC_SPECIFY:   opc_need = 3'h2;
      `FCRM_OPC_CONFIGURE: opc_need = 3'h3;
      `FCRM_OPC_SENSE_INT: opc_need = 3'h0;
      `FCRM_OPC_READ:      opc_need = 3'h7;
      `FCRM_OPC_READ_DEL:  opc_need = 3'h7;
      default:             opc_ok   = 1'b0;
    endcase
  end

  fcrm_parmem u_parmem (
    .clk   (clk),
    .we    (cmd_wr),
    .waddr (byte_cnt_reg),
    .wdata (avs_writedata),
    .raddr (3'h0),
    .rdata (pm_rdata)
  );

  // ==========================================================
  // Third and fourth status bytes
  wire       trk_diff = (id_track != held_track);
  wire [7:0] sr2_next;
  assign sr2_next[7] = 1'b0;
  assign sr2_next[`FCRM_SR2_CTLMARK] =
    (found_data_mark & read_deleted_cmd) |
    (found_deleted_mark & ~read_deleted_cmd);
  assign sr2_next[`FCRM_SR2_CRCERR] = data_crc_bad;
  assign sr2_next[`FCRM_SR2_WRONGCYL] = trk_diff;
  assign sr2_next[3:2] = 2'b00;
  assign sr2_next[`FCRM_SR2_BADTRK] =
    trk_diff & (id_track == `FCRM_BAD_TRACK);
  assign sr2_next[`FCRM_SR2_NOMARK] =
    ~found_data_mark & ~found_deleted_mark;

  wire [7:0] sr3 = `FCRM_SR3_ONES | {1'b0, wp_s, 1'b0, t0_s, 1'b0,
                   head_select_output, ~drive_select_one_n,
                   ~drive_select_zero_n};

  // ==========================================================
  // Reset sources and host registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drvout_reg  <= `FCRM_DRVOUT_RST;
      dsr_rst_reg <= 1'b0;
      cfg_reg     <= `FCRM_CFG_RST;
      spec_reg    <= 8'h00;
    end else begin
      if (ext_s) begin
        drvout_reg  <= `FCRM_DRVOUT_RST;
        dsr_rst_reg <= 1'b0;
      end else begin
        dsr_rst_reg <= 1'b0;
        if (wr_go && avs_address == `FCRM_IDX_DRVOUT) begin
          drvout_reg <= avs_writedata;
        end else if (wr_go && avs_address == `FCRM_IDX_DSR) begin
          dsr_rst_reg <= avs_writedata[`FCRM_DSR_RESET];
        end
      end
      if (wr_go && avs_address == `FCRM_IDX_CFG) begin
        cfg_reg <= avs_writedata;
      end
      // Second specify parameter carries the non-DMA bit
      if (cmd_wr && byte_cnt_reg == 3'h2 &&
          pm_rdata[4:0] == `FCRM_OPC_SPECIFY) begin
        spec_reg <= avs_writedata;
      end else if (wr_go && avs_address == `FCRM_IDX_SPEC) begin
        spec_reg <= avs_writedata;
      end
    end
  end

  // ==========================================================
  // Command phase sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg    <= PH_CMD;
      proc_cnt_reg <= 4'h0;
      byte_cnt_reg <= 3'h0;
      need_reg     <= 3'h0;
      res_cnt_reg  <= 2'h0;
      req_reg      <= 1'b0;
      dir_reg      <= 1'b0;
      invalid_reg  <= 1'b0;
      st0_reg      <= 8'h00;
      sr2_reg      <= 8'h00;
      polling_reg  <= 1'b1;
      fifo_cfg_reg <= 1'b0;
    end else if (core_rst) begin
      phase_reg    <= PH_CMD;
      proc_cnt_reg <= 4'h0;
      byte_cnt_reg <= 3'h0;
      need_reg     <= 3'h0;
      res_cnt_reg  <= 2'h0;
      req_reg      <= 1'b0;
      dir_reg      <= 1'b0;
      invalid_reg  <= 1'b0;
      st0_reg      <= 8'h00;
      sr2_reg      <= 8'h00;
      polling_reg  <= 1'b1;
      fifo_cfg_reg <= 1'b0;
    end else begin
      if (sector_done) begin
        sr2_reg <= sr2_next;
      end
      case (phase_reg)
        PH_CMD: begin
          req_reg <= 1'b1;
          dir_reg <= 1'b0;
          if (cmd_wr) begin
            req_reg      <= 1'b0;
            phase_reg    <= PH_PROC;
            proc_cnt_reg <= `FCRM_PROC_CYC;
            if (byte_cnt_reg == 3'h0) begin
              need_reg    <= opc_need;
              invalid_reg <= ~opc_ok;
            end
          end
        end
        PH_PROC: begin
          if (proc_cnt_reg != 4'h0) begin
            proc_cnt_reg <= proc_cnt_reg - 4'h1;
          end else if (invalid_reg) begin
            st0_reg      <= 8'h80;
            byte_cnt_reg <= 3'h0;
            phase_reg    <= PH_RES;
            res_cnt_reg  <= 2'h0;
            req_reg      <= 1'b1;
            dir_reg      <= 1'b1;
          end else if (byte_cnt_reg != need_reg) begin
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
            phase_reg    <= PH_CMD;
          end else begin
            byte_cnt_reg <= 3'h0;
            req_reg      <= 1'b0;
            if (pm_rdata[4:0] == `FCRM_OPC_CONFIGURE) begin
              polling_reg  <= 1'b0;
              fifo_cfg_reg <= 1'b1;
            end
            if (pm_rdata[4:0] == `FCRM_OPC_READ ||
                pm_rdata[4:0] == `FCRM_OPC_READ_DEL) begin
              phase_reg <= PH_EXEC;
            end else if (pm_rdata[4:0] == `FCRM_OPC_SENSE_INT) begin
              st0_reg     <= 8'h00;
              phase_reg   <= PH_RES;
              res_cnt_reg <= 2'h0;
              req_reg     <= 1'b1;
              dir_reg     <= 1'b1;
            end else begin
              phase_reg <= PH_CMD;
            end
          end
        end
        PH_EXEC: begin
          if (sector_done) begin
            phase_reg   <= PH_RES;
            res_cnt_reg <= 2'h0;
            req_reg     <= 1'b1;
            dir_reg     <= 1'b1;
          end
        end
        default: begin
          if (res_rd) begin
            res_cnt_reg <= res_cnt_reg + 2'h1;
            if (res_cnt_reg == 2'h2) begin
              phase_reg <= PH_CMD;
              req_reg   <= 1'b1;
              dir_reg   <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Avalon slave: one wait cycle then answer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 8'h00;
    end else begin
      avs_waitrequest <= ~(acc & avs_waitrequest);
      if (rd_go) begin
        if (avs_address == `FCRM_IDX_MSR) begin
          avs_readdata <= {req_reg, dir_reg, 1'b0,
                           (phase_reg != PH_CMD), 4'h0};
        end else if (avs_address == `FCRM_IDX_DATA) begin
          if (phase_reg != PH_RES) begin
            avs_readdata <= 8'h00;
          end else if (res_cnt_reg == 2'h0) begin
            avs_readdata <= st0_reg;
          end else if (res_cnt_reg == 2'h1) begin
            avs_readdata <= sr2_reg;
          end else begin
            avs_readdata <= sr3;
          end
        end else if (avs_address == `FCRM_IDX_DRVOUT) begin
          avs_readdata <= drvout_reg;
        end else if (avs_address == `FCRM_IDX_CFG) begin
          avs_readdata <= cfg_reg;
        end else if (avs_address == `FCRM_IDX_SR2) begin
          avs_readdata <= sr2_reg;
        end else if (avs_address == `FCRM_IDX_SR3) begin
          avs_readdata <= sr3;
        end else if (avs_address == `FCRM_IDX_SPEC) begin
          avs_readdata <= spec_reg;
        end else begin
          avs_readdata <= 8'h00;
        end
      end
    end
  end

  // ==========================================================
  // Drive, DMA and status outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      external_reset_pin_n <= 1'b0;
      head_select_output   <= 1'b0;
      drive_select_zero_n  <= 1'b1;
      drive_select_one_n   <= 1'b1;
      density_select_out   <= 1'b1;
      dma_request          <= 1'b0;
      dma_burst            <= 1'b0;
      irq_out              <= 1'b0;
      fifo_enable          <= 1'b0;
      polling_enable       <= 1'b0;
      core_in_reset        <= 1'b1;
    end else begin
      external_reset_pin_n <= ~ext_s;
      core_in_reset        <= core_rst;
      head_select_output   <= head_sel;
      drive_select_zero_n  <= ~(drive_sel == 2'b00);
      drive_select_one_n   <= ~(drive_sel == 2'b01);
      density_select_out   <= is_third ? ~high_density :
                              high_density;
      dma_burst            <= cfg_reg[`FCRM_CFG_BURST];
      fifo_enable          <= fifo_cfg_reg & ~core_rst &
                              (phase_reg == PH_EXEC);
      polling_enable       <= polling_reg & ~core_rst;
      irq_out              <= gate_en & ~core_rst &
                              (irq_event | (phase_reg == PH_RES));
      if (core_rst || !gate_en || !dma_mode || phase_reg != PH_EXEC) begin
        dma_request <= 1'b0;
      end else if (dma_ack && !cfg_reg[`FCRM_CFG_BURST]) begin
        dma_request <= 1'b0;
      end else begin
        dma_request <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- src/fcrm_consts.vh
`ifndef FCRM_CONSTS_VH
`define FCRM_CONSTS_VH
// Avalon word offsets (byte address = 4 * index)
`define FCRM_IDX_MSR        3'h0
`define FCRM_IDX_DATA       3'h1
`define FCRM_IDX_DRVOUT     3'h2
`define FCRM_IDX_DSR        3'h3
`define FCRM_IDX_CFG        3'h4
`define FCRM_IDX_SR2        3'h5
`define FCRM_IDX_SR3        3'h6
`define FCRM_IDX_SPEC       3'h7
// Main status fields
`define FCRM_MSR_REQ        7
`define FCRM_MSR_DIR        6
`define FCRM_MSR_BUSY       4
// Drive output register fields
`define FCRM_DRVOUT_RESET_N 2
`define FCRM_DRVOUT_DMAEN   3
`define FCRM_DRVOUT_RST     8'h00
// Rate select register reset bit
`define FCRM_DSR_RESET      7
// Logical device config fields
`define FCRM_CFG_IDENT      3
`define FCRM_CFG_ENC        2
`define FCRM_CFG_BURST      1
`define FCRM_CFG_RST        8'h0E
// Specify: bit 0 set selects non-DMA
`define FCRM_SPEC_NDMA      0
// Status byte field positions
`define FCRM_SR2_CTLMARK    6
`define FCRM_SR2_CRCERR     5
`define FCRM_SR2_WRONGCYL   4
`define FCRM_SR2_BADTRK     1
`define FCRM_SR2_NOMARK     0
`define FCRM_SR3_WP         6
`define FCRM_SR3_TZERO      4
`define FCRM_SR3_HEAD       2
`define FCRM_SR3_ONES       8'h28
`define FCRM_BAD_TRACK      8'hFF
// Mode encodings {ident, enc}
`define FCRM_MODE_FIRST_A   2'b11
`define FCRM_MODE_FIRST_B   2'b10
`define FCRM_MODE_SECOND    2'b01
`define FCRM_MODE_THIRD     2'b00
// Byte processing latency in cycles
`define FCRM_PROC_CYC       4'h4
// Opcode values, compared on the low 5 bits
`define FCRM_OPC_SPECIFY    5'h03
`define FCRM_OPC_CONFIGURE  5'h13
`define FCRM_OPC_SENSE_INT  5'h08
`define FCRM_OPC_READ       5'h06
`define FCRM_OPC_READ_DEL   5'h0C
`endif

//--- src/fcrm_sync.v
`timescale 1ns/1ns
`default_nettype none
module fcrm_sync (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Data
  input  wire d_in,
  output reg  q_out
);
  reg meta_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q_out    <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- src/fcrm_parmem.v
`timescale 1ns/1ns
`default_nettype none
// Small store of command bytes, registered read data
module fcrm_parmem (
  // Clock
  input  wire       clk,
  // Write port
  input  wire       we,
  input  wire [2:0] waddr,
  input  wire [7:0] wdata,
  // Read port
  input  wire [2:0] raddr,
  output reg  [7:0] rdata
);
  reg [7:0] mem [0:7];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

//--- tb/fcrm_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Port checker for the floppy control core
module fcrm_sva (
  // Clock and reset
  input wire       clk,
  input wire       rst_n,
  // Register bus
  input wire [2:0] avs_address,
  input wire       avs_read,
  input wire       avs_write,
  input wire [7:0] avs_writedata,
  input wire [7:0] avs_readdata,
  input wire       avs_waitrequest,
  // Pins and status
  input wire       external_reset_ctl_bit,
  input wire       external_reset_pin_n,
  input wire       head_select_output,
  input wire       density_select_out,
  input wire       high_density,
  input wire       dma_request,
  input wire       dma_burst,
  input wire       fifo_enable,
  input wire       core_in_reset
);
  logic [1:0] mode_q;
  logic       ndma_q;
  wire        wr_ok = avs_write && !avs_waitrequest;
  wire        rd_go = avs_read && avs_waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the mode bits and the non-DMA bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 2'b11;
      ndma_q <= 1'b0;
    end else if (wr_ok && avs_address == 3'h4) begin
      mode_q <= avs_writedata[3:2];
    end else if (wr_ok && avs_address == 3'h7) begin
      ndma_q <= avs_writedata[0];
    end
  end
  a_sr2_spare: assert property (
    rd_go && avs_address == 3'h5 |=> (avs_readdata & 8'h8C) == 8'h00)
    else $error("status two spare bits wrong");
  a_sr3_spare: assert property (
    rd_go && avs_address == 3'h6 |=> (avs_readdata & 8'hA8) == 8'h28)
    else $error("status three spare bits wrong");
  a_sr3_head: assert property (
    rd_go && avs_address == 3'h6 |=> avs_readdata[2] == head_select_output)
    else $error("head echo differs from head pin");
  a_ext_reset: assert property (
    external_reset_ctl_bit [*5] |-> !external_reset_pin_n && core_in_reset)
    else $error("external reset not applied");
  a_reset_idle: assert property (
    core_in_reset |-> !fifo_enable && !dma_request)
    else $error("activity during core reset");
  a_burst_follow: assert property (
    wr_ok && avs_address == 3'h4 |-> ##2
    dma_burst == $past(avs_writedata[1], 2))
    else $error("burst select does not follow config");
  a_dens_low: assert property (
    (mode_q == 2'b00 && $stable(mode_q) && $stable(high_density)) [*3]
    |-> density_select_out == !high_density)
    else $error("density not active low");
  a_dens_high: assert property (
    (mode_q != 2'b00 && $stable(mode_q) && $stable(high_density)) [*3]
    |-> density_select_out == high_density)
    else $error("density not active high");
  a_ndma_quiet: assert property (
    ndma_q && $past(ndma_q, 2) |-> !dma_request)
    else $error("DMA request in non-DMA mode");
  c_data_write: cover property (wr_ok && avs_address == 3'h1);
  c_mode_low: cover property (mode_q == 2'b00 && !density_select_out);
  c_reset_exit: cover property (core_in_reset ##1 !core_in_reset);
endmodule

bind fcrm_top fcrm_sva u_sva (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .external_reset_ctl_bit(external_reset_ctl_bit),
  .external_reset_pin_n(external_reset_pin_n),
  .head_select_output(head_select_output),
  .density_select_out(density_select_out), .high_density(high_density),
  .dma_request(dma_request), .dma_burst(dma_burst),
  .fifo_enable(fifo_enable), .core_in_reset(core_in_reset)
);
`default_nettype wire

//--- tb/fcrm_host.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Host processor and DMA acknowledge model
module fcrm_host (
  // Clock
  input  wire        clk,
  // Avalon-MM master
  output logic [2:0] avs_address = 3'h0,
  output logic       avs_read = 1'b0,
  output logic       avs_write = 1'b0,
  output logic [7:0] avs_writedata = 8'h00,
  input  wire  [7:0] avs_readdata,
  input  wire        avs_waitrequest,
  // DMA handshake
  input  wire        dma_request,
  output logic       dma_ack = 1'b0
);
  int timeouts = 0;
  always @(posedge clk) dma_ack <= dma_request && !dma_ack;
  // One bus cycle, held until waitrequest is seen low or after 50 more cycles
  task automatic xfer(input logic w, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    for (i = 0; i < 50 && avs_waitrequest !== 1'b0; i++)
      @(posedge clk);
    if (avs_waitrequest !== 1'b0)
      timeouts++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // Command byte, written once ready for input or after 40 status polls
  task automatic cmd(input logic [7:0] b);
    logic [7:0] m;
    int i;
    m = 8'h00;
    for (i = 0; i < 40 && m[7:6] !== 2'b10; i++)
      xfer(1'b0, 3'h0, 8'h00, m);
    if (m[7:6] !== 2'b10)
      timeouts++;
    xfer(1'b1, 3'h1, b, m);
  endtask
endmodule
`default_nettype wire

//--- tb/fcrm_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module fcrm_top_bench;
  // ========================================
  // Stimulus and observed signals
  logic       clk = 1'b0, rst_n = 1'b0, ext_rst = 1'b0, wp_n = 1'b1;
  logic       tz_n = 1'b1, hs = 1'b0, sdone = 1'b0, irq_ev = 1'b0, hd = 1'b1;
  logic [3:0] ev = 4'h0;
  logic [7:0] idt = 8'h05, m;
  logic [1:0] dsel = 2'b00;
  logic [2:0] a;
  logic       rd, wr, dreq, dack, hsel, ds0_n, ds1_n, dens, burst, irq;
  logic       pin_n, fifo_en, poll_en, core_rst, wreq;
  logic [7:0] wd, rdat;
  int         n_fail = 0, checks_done = 0;
  initial forever #25 clk = ~clk;
  fcrm_top dut (
    .clk(clk), .rst_n(rst_n), .avs_address(a), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .external_reset_ctl_bit(ext_rst),
    .external_reset_pin_n(pin_n), .write_protect_n(wp_n),
    .track_zero_input_n(tz_n), .head_select_output(hsel),
    .drive_select_zero_n(ds0_n), .drive_select_one_n(ds1_n),
    .density_select_out(dens), .high_density(hd),
    .sector_done(sdone), .read_deleted_cmd(ev[3]),
    .found_data_mark(ev[2]), .found_deleted_mark(ev[1]),
    .data_crc_bad(ev[0]), .id_track(idt), .held_track(8'h05),
    .head_sel(hs), .drive_sel(dsel), .dma_request(dreq), .dma_ack(dack),
    .dma_burst(burst), .irq_out(irq), .irq_event(irq_ev),
    .fifo_enable(fifo_en), .polling_enable(poll_en),
    .core_in_reset(core_rst)
  );
  fcrm_host host (
    .clk(clk), .avs_address(a), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .dma_request(dreq), .dma_ack(dack)
  );
  task automatic wrap_up;
    n_fail += host.timeouts;
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wait_core(input logic v);
    int i;
    for (i = 0; i < 100 && core_rst !== v; i++)
      @(posedge clk);
    cmp({7'h00, core_rst}, {7'h00, v});
    if (core_rst !== v)
      wrap_up;
  endtask
  task automatic wait_msr(input logic [7:0] e);
    int i;
    m = ~e;
    for (i = 0; i < 60 && m !== e; i++)
      host.xfer(1'b0, 3'h0, 8'h00, m);
    cmp(m, e);
    if (m !== e)
      wrap_up;
  endtask
  // ========================================
  // Scenarios
  task automatic t_reset;
    cmp({7'h00, core_rst}, 8'h01);
    cmp({7'h00, pin_n}, 8'h01);
    host.xfer(1'b1, 3'h7, 8'h01, m);
    host.xfer(1'b1, 3'h2, 8'h04, m);
    wait_core(1'b0);
    wait_msr(8'h80);
    cmp({7'h00, poll_en}, 8'h01);
    cmp({7'h00, fifo_en}, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_invalid;
    host.cmd(8'h1F);
    wait_msr(8'hD0);
    cmp({7'h00, fifo_en}, 8'h00);
    host.xfer(1'b0, 3'h1, 8'h00, m);
    cmp(m, 8'h80);
    host.xfer(1'b0, 3'h1, 8'h00, m);
    host.xfer(1'b0, 3'h1, 8'h00, m);
    wait_msr(8'h80);
    $display("invalid opcode test done");
  endtask
  task automatic t_read(input logic [7:0] op, input logic [3:0] e,
                        input logic [7:0] it, input logic [7:0] x,
                        input logic [7:0] y);
    int i;
    ev <= e;
    idt <= it;
    wp_n <= ~y[6];
    tz_n <= ~y[4];
    hs <= y[2];
    dsel <= {~y[1] & ~y[0], y[1]};
    host.cmd(op);
    for (i = 0; i < 7; i++)
      host.cmd(8'h00);
    host.xfer(1'b0, 3'h0, 8'h00, m);
    cmp(m & 8'h80, 8'h00);
    repeat (4) @(posedge clk);
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    wait_msr(8'hD0);
    host.xfer(1'b0, 3'h1, 8'h00, m);
    host.xfer(1'b0, 3'h1, 8'h00, m);
    cmp(m, x);
    host.xfer(1'b0, 3'h1, 8'h00, m);
    cmp(m, y);
    cmp({7'h00, hsel}, {7'h00, y[2]});
    host.xfer(1'b1, 3'h5, 8'hFF, m);
    host.xfer(1'b0, 3'h5, 8'h00, m);
    cmp(m, x);
    wait_msr(8'h80);
    $display("read case %h done", op);
  endtask
  task automatic t_mode(input logic [1:0] md, input logic bu,
                        input logic ie);
    host.xfer(1'b1, 3'h4, {4'h0, md, bu, 1'b0}, m);
    host.xfer(1'b1, 3'h2, 8'h04, m);
    irq_ev <= 1'b1;
    @(posedge clk);
    irq_ev <= 1'b0;
    @(negedge clk);
    cmp({7'h00, irq}, {7'h00, ie});
    repeat (4) @(posedge clk);
    cmp({7'h00, dens}, {7'h00, md != 2'b00});
    cmp({7'h00, burst}, {7'h00, bu});
    hd <= 1'b0;
    repeat (4) @(posedge clk);
    cmp({7'h00, dens}, {7'h00, md == 2'b00});
    hd <= 1'b1;
    $display("mode %b test done", md);
  endtask
  task automatic t_resets;
    host.cmd(8'h06);
    host.xfer(1'b1, 3'h3, 8'h80, m);
    wait_msr(8'h80);
    wait_core(1'b0);
    host.xfer(1'b1, 3'h2, 8'h00, m);
    wait_core(1'b1);
    host.xfer(1'b1, 3'h3, 8'h80, m);
    repeat (30) @(posedge clk);
    cmp({7'h00, core_rst}, 8'h01);
    host.xfer(1'b1, 3'h2, 8'h04, m);
    wait_core(1'b0);
    ext_rst <= 1'b1;
    repeat (6) @(posedge clk);
    cmp({7'h00, pin_n}, 8'h00);
    ext_rst <= 1'b0;
    repeat (30) @(posedge clk);
    cmp({7'h00, core_rst}, 8'h01);
    host.xfer(1'b0, 3'h7, 8'h00, m);
    cmp(m, 8'h01);
    host.xfer(1'b1, 3'h2, 8'h04, m);
    wait_core(1'b0);
    wait_msr(8'h80);
    $display("reset sources test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_invalid;
    t_read(8'h06, 4'b0011, 8'hFF, 8'h72, 8'h6D);
    t_read(8'h0C, 4'b1100, 8'h05, 8'h40, 8'h38);
    t_read(8'h06, 4'b0000, 8'h07, 8'h11, 8'h29);
    t_read(8'h06, 4'b0100, 8'h05, 8'h00, 8'h7C);
    t_mode(2'b11, 1'b1, 1'b0);
    t_mode(2'b10, 1'b0, 1'b0);
    t_mode(2'b00, 1'b1, 1'b0);
    t_mode(2'b01, 1'b0, 1'b1);
    t_resets;
    wrap_up;
  end
endmodule
`default_nettype wire
